// File: pod_front_end_pkg.sv
package pod_front_end_pkg;

  // Clock and serial timing
  localparam int unsigned CLOCK_HZ        = 50000000;     // System clock rate
  localparam int unsigned BAUD_DEFAULT    = 9600;         // Factory bit rate
  localparam int unsigned BIT_CYCLES      = CLOCK_HZ / BAUD_DEFAULT; // Clocks per bit
  localparam int unsigned HALF_CYCLES     = BIT_CYCLES / 2;          // Clocks to mid bit
  localparam int unsigned BAUD_CNT_W      = 13;           // Width of bit timer

  // Character framing
  localparam int unsigned DATA_BITS       = 7;            // Data bits per character
  localparam int unsigned STOP_BITS       = 1;            // Stop bits per character

  // Characters
  localparam logic [6:0]  CHAR_CR         = 7'h0D;        // Carriage return, code 13
  localparam logic [6:0]  CHAR_BANG       = 7'h21;        // Address select lead-in
  localparam logic [6:0]  CHAR_ZERO       = 7'h30;        // Digit zero
  localparam logic [6:0]  CHAR_NINE       = 7'h39;        // Digit nine
  localparam logic [6:0]  CHAR_UA         = 7'h41;        // Upper case A
  localparam logic [6:0]  CHAR_UF         = 7'h46;        // Upper case F
  localparam logic [6:0]  CHAR_LA         = 7'h61;        // Lower case a
  localparam logic [6:0]  CHAR_LZ         = 7'h7A;        // Lower case z
  localparam logic [6:0]  CASE_BIT        = 7'h20;        // Case difference bit

  // Addressing
  localparam logic [7:0]  NODE_ADDR_RESET = 8'h00;        // Address as shipped
  localparam logic [7:0]  NODE_ADDR_NONE  = 8'h00;        // Non-addressed value

  // Command length limit
  localparam logic [7:0]  CMD_MAX_LEN     = 8'hFF;        // Longest legal message

  // Output ports
  localparam int unsigned PORT0_OUT_W     = 7;            // Shared port outputs
  localparam int unsigned PORT0_IN_W      = 8;            // Shared port inputs
  localparam int unsigned PORT1_W         = 8;            // Mux port outputs

  // Receive states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_e;

  // Transmit states
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_state_e;

  // Command parse states
  typedef enum logic [2:0] {
    PS_FIRST = 3'b000,
    PS_HI    = 3'b001,
    PS_LO    = 3'b010,
    PS_END   = 3'b011,
    PS_BODY  = 3'b100
  } parse_state_e;

endpackage

// File: pod_command_front_end.sv
`timescale 1ns/100ps

module pod_command_front_end
  import pod_front_end_pkg::*;
(
  input  wire logic                   clock,             // System clock, 50 MHz
  input  wire logic                   rstn,              // Synchronous reset, active low
  input  wire logic                   line_rx,           // Received serial line, idle high
  output logic                        line_tx,           // Transmit serial line, idle high
  output logic                        line_tx_oe,        // Line driver enable, high drives
  input  wire logic [7:0]             node_addr,         // Stored node address
  output logic                        cmd_valid,         // Pulse, command char accepted
  output logic [6:0]                  cmd_char,          // Folded command character
  output logic                        cmd_end,           // Pulse, command ended by CR
  output logic                        cmd_abort,         // Pulse, command discarded
  input  wire logic                   reply_valid,       // Reply char offered
  input  wire logic [6:0]             reply_char,        // Reply character
  output logic                        reply_ready,       // Reply char taken
  input  wire logic [2:0]             point_adc,         // Analog channel of a point
  input  wire logic [3:0]             point_submux,      // Submux channel of a point
  output logic [7:0]                  point_num,         // Combined point number
  output logic                        adc_chan_bit2,     // Decoded analog channel bit 2
  output logic                        adc_chan_bit1,     // Decoded analog channel bit 1
  output logic                        adc_chan_bit0,     // Decoded analog channel bit 0
  output logic                        submux_sel_bit3,   // Decoded submux bit 3
  output logic                        submux_sel_bit2,   // Decoded submux bit 2
  output logic                        submux_sel_bit1,   // Decoded submux bit 1
  output logic                        submux_sel_bit0,   // Decoded submux bit 0
  input  wire logic                   port0_wr,          // Host write to shared port
  input  wire logic [PORT0_OUT_W-1:0] port0_wdata,       // Shared port write data
  output logic [PORT0_OUT_W-1:0]      shared_inout_port, // Shared port output drive
  input  wire logic [PORT0_IN_W-1:0]  port0_pins,        // Shared port input pins
  output logic [PORT0_IN_W-1:0]       port0_rdata,       // Captured shared port inputs
  input  wire logic                   port1_submux_mode, // Port1 runs the submux
  input  wire logic                   port1_wr,          // Host write to mux port
  input  wire logic [PORT1_W-1:0]     port1_wdata,       // Mux port write data
  input  wire logic [PORT1_W-1:0]     port1_ctrl,        // Pod control drive for port1
  output logic [PORT1_W-1:0]          port1_out,         // Mux port output drive
  output logic                        addressed_mode,    // Level, addressed mode active
  output logic                        selected           // Level, pod accepts commands
);

  // Receiver state
  rx_state_e              rx_state_reg;                  // Receive state
  logic [BAUD_CNT_W-1:0]  rx_cnt_reg;                    // Receive bit timer
  logic [2:0]             rx_bit_reg;                    // Receive bit index
  logic [7:0]             rx_shift_reg;                  // Data and parity bits
  logic                   rx_done;                       // Character complete
  logic                   rx_good;                       // Parity and stop fine
  logic [6:0]             rx_char;                       // Received data
  logic                   rx_tick;                       // Bit timer expiry

  // Parser state
  parse_state_e           ps_reg;                        // Parse state
  logic [7:0]             sel_addr_reg;                  // Address being collected
  logic                   selected_reg;                  // Select flag
  logic                   bad_reg;                       // Command holds parity or stop error
  logic [7:0]             len_reg;                       // Characters in command
  logic                   cr_pending_reg;                // Select answer requested

  // Transmitter state
  tx_state_e              tx_state_reg;                  // Transmit state
  logic [BAUD_CNT_W-1:0]  tx_cnt_reg;                    // Transmit bit timer
  logic [2:0]             tx_bit_reg;                    // Transmit bit index
  logic [7:0]             tx_shift_reg;                  // Data and parity to send
  logic                   tx_tick;                       // Bit timer expiry
  logic                   tx_load;                       // Start a character
  logic                   tx_from_sel;                   // Char is select answer
  logic [6:0]             tx_char;                       // Char to start

  // Decode of received character
  logic [6:0]             up_char;                       // Case-folded char
  logic                   is_digit;                      // 0 to 9
  logic                   is_hexl;                       // A to F after folding
  logic                   is_hex;                        // Any hex digit
  logic [3:0]             hex_val;                       // Digit value
  logic                   is_cr;                         // Terminator
  logic                   is_bang;                       // Select lead-in
  logic                   match;                         // Collected address is ours
  logic                   body_char;                     // Char belongs to a command body

  // Mode decode from stored address
  assign addressed_mode = (node_addr != NODE_ADDR_NONE);
  assign selected       = addressed_mode ? selected_reg : 1'b1;

  // Receive decode
  assign rx_tick = (rx_cnt_reg == '0);
  assign rx_char = rx_shift_reg[6:0];
  assign rx_good = ~^rx_shift_reg & line_rx;
  assign rx_done = (rx_state_reg == RX_STOP) && rx_tick;

  // Case folding and hex digit decode
  assign up_char  = (rx_char >= CHAR_LA && rx_char <= CHAR_LZ) ? (rx_char & ~CASE_BIT) : rx_char;
  assign is_digit = (up_char >= CHAR_ZERO) && (up_char <= CHAR_NINE);
  assign is_hexl  = (up_char >= CHAR_UA) && (up_char <= CHAR_UF);
  assign is_hex   = is_digit | is_hexl;
  assign hex_val  = is_digit ? up_char[3:0] : 4'(up_char[3:0] + 4'h9);
  assign is_cr    = (up_char == CHAR_CR);
  assign is_bang  = (up_char == CHAR_BANG);
  assign match    = (sel_addr_reg == node_addr) && (sel_addr_reg != NODE_ADDR_NONE);
  // First char of a command counts too, unless it opens a select
  assign body_char = (ps_reg == PS_BODY) || (ps_reg == PS_FIRST && !is_bang);

  // Receiver, bit timer starts at half a bit to sample mid bit
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg   <= '0;
      rx_bit_reg   <= '0;
      rx_shift_reg <= 8'h00;
    end else begin
      rx_cnt_reg <= rx_tick ? BAUD_CNT_W'(BIT_CYCLES - 1) : BAUD_CNT_W'(rx_cnt_reg - 1'b1);
      case (rx_state_reg)
        RX_IDLE: begin
          if (!line_rx) begin
            rx_state_reg <= RX_START;
            rx_cnt_reg   <= BAUD_CNT_W'(HALF_CYCLES - 1);
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_state_reg <= line_rx ? RX_IDLE : RX_DATA; // Glitch rejected
            rx_bit_reg   <= '0;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_shift_reg <= {line_rx, rx_shift_reg[7:1]};
            rx_bit_reg   <= 3'(rx_bit_reg + 1'b1);
            if (rx_bit_reg == 3'(DATA_BITS)) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        default: begin
          if (rx_tick) begin
            rx_state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Command parser and address select
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ps_reg         <= PS_FIRST;
      sel_addr_reg   <= NODE_ADDR_RESET;
      selected_reg   <= 1'b0;
      bad_reg        <= 1'b0;
      len_reg        <= 8'h00;
      cr_pending_reg <= 1'b0;
    end else begin
      if (tx_load && tx_from_sel) begin
        cr_pending_reg <= 1'b0;
      end
      if (rx_done) begin
        len_reg <= (len_reg == CMD_MAX_LEN) ? len_reg : 8'(len_reg + 1'b1);
        if (!rx_good) begin
          bad_reg <= 1'b1;
        end
        case (ps_reg)
          PS_FIRST: begin
            ps_reg <= (is_bang && rx_good) ? PS_HI : PS_BODY;
            if (is_cr) begin
              ps_reg  <= PS_FIRST;
              bad_reg <= 1'b0;
              len_reg <= 8'h00;
            end
          end
          PS_HI: begin
            sel_addr_reg <= {hex_val, 4'h0};
            ps_reg       <= is_hex ? PS_LO : PS_BODY;
          end
          PS_LO: begin
            sel_addr_reg <= {sel_addr_reg[7:4], hex_val};
            ps_reg       <= is_hex ? PS_END : PS_BODY;
          end
          PS_END: begin
            if (is_cr) begin
              ps_reg  <= PS_FIRST;
              bad_reg <= 1'b0;
              len_reg <= 8'h00;
              if (rx_good && !bad_reg && addressed_mode) begin
                selected_reg   <= match;
                cr_pending_reg <= match;
              end
            end else begin
              ps_reg <= PS_BODY;
            end
          end
          default: begin
            if (is_cr) begin
              ps_reg  <= PS_FIRST;
              bad_reg <= 1'b0;
              len_reg <= 8'h00;
            end
          end
        endcase
      end
    end
  end

  // Character stream to the command executor, select commands kept internal
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
      cmd_char  <= 7'h00;
      cmd_end   <= 1'b0;
      cmd_abort <= 1'b0;
    end else begin
      cmd_valid <= rx_done && rx_good && selected && !is_cr && body_char;
      cmd_char  <= up_char;
      cmd_end   <= rx_done && is_cr && rx_good && !bad_reg && selected && ps_reg == PS_BODY;
      cmd_abort <= rx_done && is_cr && (!rx_good || bad_reg) && selected;
    end
  end

  // Transmit source, select answer first, then executor replies
  assign tx_from_sel = cr_pending_reg;
  assign tx_char     = tx_from_sel ? CHAR_CR : reply_char;
  assign tx_load     = (tx_state_reg == TX_IDLE) && (tx_from_sel || (reply_valid && selected));
  assign reply_ready = tx_load && !tx_from_sel;
  assign tx_tick     = (tx_cnt_reg == '0);

  // Transmitter, even parity in bit 7
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg   <= '0;
      tx_bit_reg   <= '0;
      tx_shift_reg <= 8'h00;
      line_tx      <= 1'b1;
      line_tx_oe   <= 1'b0;
    end else begin
      tx_cnt_reg <= tx_tick ? BAUD_CNT_W'(BIT_CYCLES - 1) : BAUD_CNT_W'(tx_cnt_reg - 1'b1);
      case (tx_state_reg)
        TX_IDLE: begin
          line_tx    <= 1'b1;
          line_tx_oe <= 1'b0;
          if (tx_load) begin
            tx_shift_reg <= {^tx_char, tx_char};
            tx_cnt_reg   <= BAUD_CNT_W'(BIT_CYCLES - 1);
            tx_state_reg <= TX_START;
            line_tx      <= 1'b0;
            line_tx_oe   <= 1'b1;
          end
        end
        TX_START: begin
          if (tx_tick) begin
            line_tx      <= tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit_reg   <= '0;
            tx_state_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_tick) begin
            tx_bit_reg <= 3'(tx_bit_reg + 1'b1);
            if (tx_bit_reg == 3'(DATA_BITS)) begin
              line_tx      <= 1'b1;                      // One stop bit
              tx_state_reg <= TX_STOP;
            end else begin
              line_tx      <= tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            end
          end
        end
        default: begin
          if (tx_tick) begin
            tx_state_reg <= TX_IDLE;
            line_tx_oe   <= 1'b0;
          end
        end
      endcase
    end
  end

  // Point number and its channel fields
  always_ff @(posedge clock) begin
    if (!rstn) begin
      point_num <= 8'h00;
    end else begin
      point_num <= {1'b0, point_adc, point_submux};
    end
  end
  assign {adc_chan_bit2, adc_chan_bit1, adc_chan_bit0} = point_num[6:4];
  assign {submux_sel_bit3, submux_sel_bit2, submux_sel_bit1, submux_sel_bit0} = point_num[3:0];

  // Digital ports, seven shared outputs plus eight mux outputs
  always_ff @(posedge clock) begin
    if (!rstn) begin
      shared_inout_port <= '0;
      port0_rdata       <= '0;
      port1_out         <= '0;
    end else begin
      port0_rdata <= port0_pins;
      if (port0_wr) begin
        shared_inout_port <= port0_wdata;
      end
      if (port1_submux_mode) begin
        port1_out <= port1_ctrl;
      end else if (port1_wr) begin
        port1_out <= port1_wdata;
      end
    end
  end

  // Assertions
  property p_quiet_unselected;
    @(posedge clock) disable iff (!rstn)
      (addressed_mode && !selected_reg && !cr_pending_reg && tx_state_reg == TX_IDLE) |=> !line_tx_oe;
  endproperty
  a_quiet_unselected: assert property (p_quiet_unselected) else $error("driver on while unselected");

  property p_port1_locked;
    @(posedge clock) disable iff (!rstn)
      port1_submux_mode |=> port1_out == $past(port1_ctrl);
  endproperty
  a_port1_locked: assert property (p_port1_locked) else $error("port1 not under pod control");

  property p_point_fmt;
    @(posedge clock) disable iff (!rstn)
      1'b1 |=> point_num == {1'b0, $past(point_adc), $past(point_submux)};
  endproperty
  a_point_fmt: assert property (p_point_fmt) else $error("bad point number");

  property p_mode;
    @(posedge clock) disable iff (!rstn)
      (node_addr == NODE_ADDR_NONE) |-> (!addressed_mode && selected);
  endproperty
  a_mode: assert property (p_mode) else $error("pod 00 not open");

  property p_abort_no_end;
    @(posedge clock) disable iff (!rstn)
      cmd_abort |-> !cmd_end;
  endproperty
  a_abort_no_end: assert property (p_abort_no_end) else $error("aborted command ended");

  sequence s_start_bit;
    tx_load ##1 (!line_tx && line_tx_oe);
  endsequence
  property p_start;
    @(posedge clock) disable iff (!rstn)
      tx_load |-> s_start_bit;
  endproperty
  a_start: assert property (p_start) else $error("missing start bit");

  property p_sel_reply;
    @(posedge clock) disable iff (!rstn)
      (tx_load && tx_from_sel) |=> tx_shift_reg[6:0] == CHAR_CR;
  endproperty
  a_sel_reply: assert property (p_sel_reply) else $error("select answer not CR");

  property p_silent_reply;
    @(posedge clock) disable iff (!rstn)
      (!selected && !cr_pending_reg) |-> !reply_ready;
  endproperty
  a_silent_reply: assert property (p_silent_reply) else $error("reply while unselected");

endmodule

// File: pod_host_model.sv
`timescale 1ns/100ps

// Host on the shared pair: sends framed characters and decodes pod replies
module pod_host_model
  import pod_front_end_pkg::*;
(
  input  wire logic clock,      // System clock
  output logic      line_rx,    // Host drive toward the pod
  input  wire logic line_tx,    // Pod transmit data
  input  wire logic line_tx_oe  // Pod line driver enable
);
  logic       bus_lvl;  // Pair level, biased to idle when nobody drives
  logic [8:0] sh;       // Receive shift, data then parity
  logic [6:0] got_q[$]; // Characters received from the pod
  logic       ok_q[$];  // Parity and stop good per character

  assign bus_lvl = line_tx_oe ? line_tx : 1'b1;

  initial line_rx = 1'b1;

  // Hold one bit for a full bit time, changes at falling edges
  task automatic put_bit(input logic b);
    line_rx = b;
    repeat (BIT_CYCLES) @(negedge clock);
  endtask

  // Start, seven data LSB first, even parity, one stop; bad flips parity
  task automatic send_char(input logic [6:0] c, input logic bad);
    put_bit(1'b0);
    for (int i = 0; i < DATA_BITS; i++) begin
      put_bit(c[i]);
    end
    put_bit(^c ^ bad);
    put_bit(1'b1);
  endtask

  // Whole command, always closed by a carriage return, kept short
  task automatic send_cmd(input string s);
    for (int i = 0; i < s.len() && i < 254; i++) begin
      send_char(7'(s[i]), 1'b0);
    end
    send_char(CHAR_CR, 1'b0);
  endtask

  // Decode each frame the pod puts on the pair, sampled mid bit
  initial begin
    forever begin
      @(negedge bus_lvl);
      repeat (HALF_CYCLES) @(posedge clock);
      // Data, parity, then the stop bit in sh[8]; rearm at mid stop bit
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYCLES) @(posedge clock);
        sh[i] = bus_lvl;
      end
      got_q.push_back(sh[6:0]);
      ok_q.push_back((^sh[7:0]) == 1'b0 && sh[8] == 1'b1);
    end
  end
endmodule

// File: test_pod_command_front_end.sv
`timescale 1ns/100ps

// Self-checking bench for the pod command front end
module test_pod_command_front_end
  import pod_front_end_pkg::*;
;
  logic       clock, rstn, line_rx, line_tx, line_tx_oe;            // Clock, reset, pair
  logic [7:0] node_addr, point_num, port0_pins, port0_rdata;        // Address, point, port0 in
  logic       cmd_valid, cmd_end, cmd_abort, reply_valid, reply_ready; // Strobes, reply handshake
  logic [6:0] cmd_char, reply_char, port0_wdata, shared_inout_port; // Characters, port0 out
  logic [2:0] point_adc;                                            // Point analog channel
  logic [3:0] point_submux;                                         // Point submux channel
  logic       adc_chan_bit2, adc_chan_bit1, adc_chan_bit0;          // Decoded analog bits
  logic       submux_sel_bit3, submux_sel_bit2, submux_sel_bit1, submux_sel_bit0; // Submux bits
  logic       port0_wr, port1_submux_mode, port1_wr, addressed_mode, selected; // Port, mode
  logic [7:0] port1_wdata, port1_ctrl, port1_out;                   // Mux port
  int         failures, tests_run, n_valid, n_end, n_abort, oe_bad; // Counters
  logic [6:0] last_char;                                            // Last accepted character
  logic       taken;                                                // Reply accepted

  pod_command_front_end dut_u (
    .clock, .rstn, .line_rx, .line_tx, .line_tx_oe, .node_addr, .cmd_valid, .cmd_char, .cmd_end,
    .cmd_abort, .reply_valid, .reply_char, .reply_ready, .point_adc, .point_submux, .point_num,
    .adc_chan_bit2, .adc_chan_bit1, .adc_chan_bit0, .submux_sel_bit3, .submux_sel_bit2,
    .submux_sel_bit1, .submux_sel_bit0, .port0_wr, .port0_wdata, .shared_inout_port, .port0_pins,
    .port0_rdata, .port1_submux_mode, .port1_wr, .port1_wdata, .port1_ctrl, .port1_out,
    .addressed_mode, .selected
  );
  pod_host_model host_u (.clock, .line_rx, .line_tx, .line_tx_oe);

  // Free-running system clock
  always #10 clock = ~clock;

  // Count command strobes and catch the driver enabled while unselected
  always @(posedge clock) begin
    if (cmd_valid === 1'b1) begin
      n_valid++;
      last_char = cmd_char;
    end
    if (cmd_end === 1'b1) n_end++;
    if (cmd_abort === 1'b1) n_abort++;
    if (line_tx_oe === 1'b1 && selected !== 1'b1) oe_bad++;
  end

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Report counts and the verdict, then stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Wait until the host has decoded n characters
  task automatic wait_rx(input int n);
    for (int i = 0; i < 12 * BIT_CYCLES && host_u.got_q.size() < n; i++) @(negedge clock);
  endtask

  // Offer one reply character and drop it once taken
  task automatic offer_reply(input logic [6:0] c);
    reply_char = c;
    reply_valid = 1'b1;
    taken = 1'b0;
    for (int i = 0; i < 2 * BIT_CYCLES && !taken; i++) begin
      #1 taken = (reply_ready === 1'b1);
      @(negedge clock);
    end
    reply_valid = 1'b0;
  endtask

  // Point number packing over corner channels
  task automatic test_point();
    logic [6:0] tbl[4] = '{7'h00, 7'h3A, 7'h7F, 7'h55};
    foreach (tbl[i]) begin
      {point_adc, point_submux} = tbl[i];
      @(negedge clock);
      check(point_num, {1'b0, tbl[i]});
      check({1'b0, adc_chan_bit2, adc_chan_bit1, adc_chan_bit0, submux_sel_bit3, submux_sel_bit2,
             submux_sel_bit1, submux_sel_bit0}, {1'b0, tbl[i]});
    end
  endtask

  // Port writes, input capture and submux ownership of port1
  task automatic test_ports();
    {port0_wr, port0_wdata, port0_pins, port1_wr, port1_wdata} = {1'b1, 7'h5A, 8'hC3, 1'b1, 8'h96};
    @(negedge clock);
    check(8'(shared_inout_port), 8'h5A);
    check(port0_rdata, 8'hC3);
    check(port1_out, 8'h96);
    {port0_wr, port1_submux_mode, port1_ctrl, port1_wdata} = {1'b0, 1'b1, 8'h3C, 8'hFF};
    @(negedge clock);
    check(port1_out, 8'h3C);
    {port1_wr, port1_submux_mode} = 2'b00;
  endtask

  // Non-addressed pod: lower case folded, CR ends, bad parity aborts
  task automatic test_plain();
    check({6'h00, addressed_mode, selected}, 8'h01);
    host_u.send_cmd("a");
    check(8'(n_valid), 8'h01);
    check(8'(last_char), 8'h41);
    check(8'(n_end), 8'h01);
    host_u.send_char(7'h62, 1'b1);
    host_u.send_char(CHAR_CR, 1'b0);
    check(8'(n_end), 8'h01);
    check(8'(n_abort), 8'h01);
    check(8'(host_u.got_q.size()), 8'h00);
  endtask

  // Addressed pod: select answer, reply, then deselect by another address
  task automatic test_select();
    node_addr = 8'h0A;
    @(negedge clock);
    check({6'h00, addressed_mode, selected}, 8'h02);
    host_u.send_cmd("!0a");
    wait_rx(1);
    check(8'(host_u.got_q[0]), 8'h0D);
    check(8'(host_u.ok_q[0]), 8'h01);
    check(8'(n_valid), 8'h01);
    check({7'h00, selected}, 8'h01);
    offer_reply(7'h41);
    check({7'h00, taken}, 8'h01);
    wait_rx(2);
    check(8'(host_u.got_q.size()), 8'h02);
    check(8'(host_u.got_q[1]), 8'h41);
    host_u.send_cmd("!0B");
    repeat (2 * BIT_CYCLES) @(negedge clock);
    check({7'h00, selected}, 8'h00);
    check(8'(host_u.got_q.size()), 8'h02);
    reply_valid = 1'b1;
    #1 check({7'h00, reply_ready}, 8'h00);
    @(negedge clock);
    reply_valid = 1'b0;
    check(8'(oe_bad), 8'h00);
  endtask

  // Watchdog sized for about thirty characters on the line
  initial begin
    repeat (1600000) @(posedge clock);
    failures++;
    print_verdict();
  end

  // Main sequence
  initial begin
    {clock, rstn, node_addr, reply_valid, reply_char, point_adc, point_submux} = '0;
    {port0_wr, port0_wdata, port0_pins, port1_submux_mode, port1_wr, port1_wdata, port1_ctrl} = '0;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    check({6'h00, line_tx_oe, line_tx}, 8'h01);
    test_point();
    test_ports();
    test_plain();
    test_select();
    print_verdict();
  end
endmodule
